// ---- otp_id_sync.sv ----
`default_nettype none

module otp_id_sync
   import simo_cfg_pkg::*;
#(
   parameter int WIDTH = CHIP_ID_WIDTH
) (
   input  wire logic             clk_sys,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] pinValue,
   output var  logic [WIDTH-1:0] idValue_r
);

   logic [WIDTH-1:0] stage1_r;
   logic [WIDTH-1:0] stage2_r;
   logic [WIDTH-1:0] stage3_r;
   wire              stagesAgree = (stage2_r == stage3_r);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         stage1_r <= '0;
         stage2_r <= '0;
         stage3_r <= '0;
      end else begin
         stage1_r <= pinValue;
         stage2_r <= stage1_r;
         stage3_r <= stage2_r;
      end
   end

   // OTP straps settle after power-up; only a value seen twice is taken
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         idValue_r <= WIDTH'(CHIP_ID_RESET);
      end else if (stagesAgree) begin
         idValue_r <= stage3_r;
      end
   end

endmodule

`default_nettype wire

// ---- simo_cfg_pkg.sv ----
`default_nettype none

package simo_cfg_pkg;

   // Register offsets
   localparam logic [7:0] ADDR_CHIP_ID     = 8'h06;
   localparam logic [7:0] ADDR_STEP_DRIVE  = 8'h07;
   localparam logic [7:0] ADDR_TARGET_CH0  = 8'h08;

   // Channel count, chip ID width and field layout of the step and drive register
   localparam int         NUM_CHANNELS     = 4;
   localparam int         CHIP_ID_WIDTH    = 5;
   localparam int         DRIVE_WIDTH      = 2;
   localparam int         DRIVE_LSB        = 0;
   localparam int         STEP_SELECT_LSB  = 2;

   // Values after reset
   localparam logic [4:0] CHIP_ID_RESET    = 5'h0b; // Arbitrary value
   localparam logic [5:0] STEP_DRIVE_RESET = 6'h00;
   localparam logic [7:0] TARGET_RESET     = 8'h00;
   localparam logic [3:0] ACTIVE_STEP_RESET = 4'h0;
   localparam logic [7:0] READ_DATA_RESET  = 8'h00;

   // Pin synchroniser depth
   localparam int         SYNC_STAGES      = 3;

   // Voltages in units of 0.1 mV
   localparam logic [15:0] VOLT_BASE       = 16'h1388;
   localparam logic [15:0] STEP_COARSE     = 16'h00fa;
   localparam logic [15:0] STEP_FINE       = 16'h007d;
   localparam logic [7:0]  MAX_COARSE_CODE = 8'hc8;

   // Switch transition times in ps
   localparam logic [13:0] DRIVE_PS_0      = 14'h0258;
   localparam logic [13:0] DRIVE_PS_1      = 14'h04b0;
   localparam logic [13:0] DRIVE_PS_2      = 14'h0708;
   localparam logic [13:0] DRIVE_PS_3      = 14'h1f40;

   typedef struct packed {
      logic [3:0] stepSelect;
      logic [1:0] driveTrim;
   } stepDrive_t;

   typedef struct packed {
      logic       wrEn;
      logic       rdEn;
      logic [7:0] addr;
      logic [7:0] wdata;
   } regReq_t;

   function automatic logic [13:0] driveTimePs(input logic [1:0] trim);
      case (trim)
         2'h0:    return DRIVE_PS_0;
         2'h1:    return DRIVE_PS_1;
         2'h2:    return DRIVE_PS_2;
         default: return DRIVE_PS_3;
      endcase
   endfunction

   function automatic logic [15:0] codeToVolt(input logic [7:0] code, input logic fine);
      logic [7:0]  effCode;
      logic [15:0] stepSize;
      effCode  = (!fine && (code > MAX_COARSE_CODE)) ? MAX_COARSE_CODE : code;
      stepSize = fine ? STEP_FINE : STEP_COARSE;
      return 16'(VOLT_BASE + 16'({8'h00, effCode} * stepSize));
   endfunction

endpackage

`default_nettype wire

// ---- simo_output_voltage_config_regs.sv ----
`default_nettype none

module simo_output_voltage_config_regs
   import simo_cfg_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire regReq_t     regReq,
   input  wire logic [4:0]  otpChipId,
   input  wire logic [2:0]  otherTargetWrite,
   output var  logic [7:0]  readData_r,
   output var  logic        readValid_r,
   output var  logic [7:0]  targetCode0_r,
   output var  logic [3:0]  activeStep_r,
   output var  logic [15:0] targetVolt0_r,
   output var  logic        targetReserved0_r,
   output var  logic [13:0] driveTransPs_r,
   output var  logic [1:0]  driveTrim_r
);

   stepDrive_t  stepDrive_r;
   logic [4:0]  chipId_r;

   wire         hitChipId    = (regReq.addr == ADDR_CHIP_ID);
   wire         hitStepDrive = (regReq.addr == ADDR_STEP_DRIVE);
   wire         hitTarget0   = (regReq.addr == ADDR_TARGET_CH0);
   wire         wrStepDrive  = regReq.wrEn && hitStepDrive;
   wire         wrTarget0    = regReq.wrEn && hitTarget0;
   wire [3:0]   targetWrite  = {otherTargetWrite, wrTarget0};

   wire [7:0]   chipIdWord   = {3'h0, chipId_r};
   wire [7:0]   stepDriveWord = {2'h0, stepDrive_r};
   wire [7:0]   readMux      = hitChipId    ? chipIdWord :
                               hitStepDrive ? stepDriveWord :
                               hitTarget0   ? targetCode0_r : 8'h00;

   wire [3:0]   activeStep_nxt;
   wire [15:0]  volt0_nxt     = codeToVolt(targetCode0_r, activeStep_r[0]);
   wire         reserved0_nxt = !activeStep_r[0] && (targetCode0_r > MAX_COARSE_CODE);

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_step
         // Step takes effect only together with a fresh target code
         assign activeStep_nxt[ch] = targetWrite[ch] ? stepDrive_r.stepSelect[ch]
                                                    : activeStep_r[ch];
      end
   endgenerate

   otp_id_sync #(
      .WIDTH     (CHIP_ID_WIDTH)
   ) u_id_sync (
      .clk_sys   (clk_sys),
      .reset     (reset),
      .pinValue  (otpChipId),
      .idValue_r (chipId_r)
   );

   // Chip identification has no write path at all
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         stepDrive_r <= STEP_DRIVE_RESET;
      end else if (wrStepDrive) begin
         stepDrive_r <= regReq.wdata[5:0];
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         targetCode0_r <= TARGET_RESET;
      end else if (wrTarget0) begin
         targetCode0_r <= regReq.wdata;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         activeStep_r <= ACTIVE_STEP_RESET;
      end else begin
         activeStep_r <= activeStep_nxt;
      end
   end

   // Reserved coarse codes clamp to the top legal voltage rather than wrap
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         targetVolt0_r     <= VOLT_BASE;
         targetReserved0_r <= 1'b0;
      end else begin
         targetVolt0_r     <= volt0_nxt;
         targetReserved0_r <= reserved0_nxt;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         driveTransPs_r <= DRIVE_PS_0;
         driveTrim_r    <= STEP_DRIVE_RESET[1:0];
      end else begin
         driveTransPs_r <= driveTimePs(stepDrive_r.driveTrim);
         driveTrim_r    <= stepDrive_r.driveTrim;
      end
   end

   // Unmapped addresses read as zero
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         readData_r  <= READ_DATA_RESET;
         readValid_r <= 1'b0;
      end else begin
         readData_r  <= regReq.rdEn ? readMux : readData_r;
         readValid_r <= regReq.rdEn;
      end
   end

   // Independent shift-and-add forms of the two voltage slopes
   wire [15:0] codeWide   = {8'h00, targetCode0_r};
   wire [15:0] coarseExp  = 16'(VOLT_BASE + (codeWide << 8) - (codeWide << 2) - (codeWide << 1));
   wire [15:0] fineExp    = 16'(VOLT_BASE + (codeWide << 7) - (codeWide << 1) - codeWide);

   property p_chip_id_read;
      @(posedge clk_sys) disable iff (reset)
      (regReq.rdEn && hitChipId) |=> (readValid_r && readData_r == {3'h0, $past(chipId_r)});
   endproperty
   a_chip_id_read: assert property (p_chip_id_read)
      else $error("chip id readback wrong");

   property p_chip_id_no_write;
      @(posedge clk_sys) disable iff (reset)
      (regReq.wrEn && hitChipId && regReq.wdata[4:0] != chipId_r)
         |=> (!(stepDrive_r != $past(stepDrive_r) || targetCode0_r != $past(targetCode0_r))
              && (chipId_r == $past(chipId_r) || chipId_r == $past(u_id_sync.stage3_r)));
   endproperty
   a_chip_id_no_write: assert property (p_chip_id_no_write)
      else $error("write to chip id disturbed another register");

   property p_step_store;
      @(posedge clk_sys) disable iff (reset)
      wrStepDrive |=> (stepDrive_r.stepSelect == $past(regReq.wdata[5:2]))
                      ##1 (driveTrim_r == $past(regReq.wdata[1:0], 2));
   endproperty
   a_step_store: assert property (p_step_store)
      else $error("step and drive register not stored");

   property p_step_deferred;
      @(posedge clk_sys) disable iff (reset)
      (!wrTarget0 && stepDrive_r.stepSelect[0] != activeStep_r[0]) |=> $stable(activeStep_r[0]);
   endproperty
   a_step_deferred: assert property (p_step_deferred)
      else $error("step changed without target write");

   property p_coarse_volt;
      @(posedge clk_sys) disable iff (reset)
      (!activeStep_r[0] && targetCode0_r <= MAX_COARSE_CODE) |=> targetVolt0_r == $past(coarseExp);
   endproperty
   a_coarse_volt: assert property (p_coarse_volt)
      else $error("coarse target voltage wrong");

   property p_coarse_reserved;
      @(posedge clk_sys) disable iff (reset)
      (!activeStep_r[0] && targetCode0_r > MAX_COARSE_CODE)
         |=> (targetReserved0_r && targetVolt0_r == 16'hd6d8);
   endproperty
   a_coarse_reserved: assert property (p_coarse_reserved)
      else $error("reserved coarse code not flagged");

   property p_fine_volt;
      @(posedge clk_sys) disable iff (reset)
      activeStep_r[0] |=> (targetVolt0_r == $past(fineExp) && !targetReserved0_r);
   endproperty
   a_fine_volt: assert property (p_fine_volt)
      else $error("fine target voltage wrong");

   property p_drive_decode;
      @(posedge clk_sys) disable iff (reset)
      wrStepDrive ##1 1'b1 |=>
         driveTransPs_r == (($past(regReq.wdata[1:0], 2) == 2'h0) ? 14'h0258 :
                            ($past(regReq.wdata[1:0], 2) == 2'h1) ? 14'h04b0 :
                            ($past(regReq.wdata[1:0], 2) == 2'h2) ? 14'h0708 : 14'h1f40);
   endproperty
   a_drive_decode: assert property (p_drive_decode)
      else $error("drive trim decode wrong");

   property p_active_load;
      @(posedge clk_sys) disable iff (reset)
      wrTarget0 |=> (activeStep_r[0] == $past(stepDrive_r.stepSelect[0])
                     && targetCode0_r == $past(regReq.wdata));
   endproperty
   a_active_load: assert property (p_active_load)
      else $error("active step not loaded on target write");

   property p_active_other;
      @(posedge clk_sys) disable iff (reset)
      otherTargetWrite[0] |=> activeStep_r[1] == $past(stepDrive_r.stepSelect[1]);
   endproperty
   a_active_other: assert property (p_active_other)
      else $error("channel 1 active step not loaded");

   property p_cov_fine_write;
      @(posedge clk_sys) disable iff (reset)
      (wrTarget0 && stepDrive_r.stepSelect[0]) ##2 activeStep_r[0];
   endproperty
   c_cov_fine_write: cover property (p_cov_fine_write);

   property p_cov_reserved;
      @(posedge clk_sys) disable iff (reset)
      targetReserved0_r;
   endproperty
   c_cov_reserved: cover property (p_cov_reserved);

   property p_cov_slow_drive;
      @(posedge clk_sys) disable iff (reset)
      driveTrim_r == 2'h3;
   endproperty
   c_cov_slow_drive: cover property (p_cov_slow_drive);

   property p_cov_id_read;
      @(posedge clk_sys) disable iff (reset)
      (regReq.rdEn && hitChipId) ##1 (readData_r != 8'h00);
   endproperty
   c_cov_id_read: cover property (p_cov_id_read);

endmodule

`default_nettype wire

// ---- test_simo_output_voltage_config_regs.sv ----
`default_nettype none

module test_simo_output_voltage_config_regs
   import simo_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clk_sys;
   logic        reset;
   regReq_t     regReq;
   logic [4:0]  otpChipId;
   logic [2:0]  otherTargetWrite;
   logic [7:0]  readData_r;
   logic        readValid_r;
   logic [7:0]  targetCode0_r;
   logic [3:0]  activeStep_r;
   logic [15:0] targetVolt0_r;
   logic        targetReserved0_r;
   logic [13:0] driveTransPs_r;
   logic [1:0]  driveTrim_r;
   int          n_fail;
   int          n_tests;

   simo_output_voltage_config_regs dut (
      .clk_sys           (clk_sys),
      .reset             (reset),
      .regReq            (regReq),
      .otpChipId         (otpChipId),
      .otherTargetWrite  (otherTargetWrite),
      .readData_r        (readData_r),
      .readValid_r       (readValid_r),
      .targetCode0_r     (targetCode0_r),
      .activeStep_r      (activeStep_r),
      .targetVolt0_r     (targetVolt0_r),
      .targetReserved0_r (targetReserved0_r),
      .driveTransPs_r    (driveTransPs_r),
      .driveTrim_r       (driveTrim_r)
   );

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Request stays up for exactly one rising edge, then is dropped
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      regReq = '{1'b1, 1'b0, a, d};
      @(negedge clk_sys);
      regReq = '{1'b0, 1'b0, 8'h00, 8'h00};
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_sys);
      regReq = '{1'b0, 1'b1, a, 8'h00};
      @(negedge clk_sys);
      regReq = '{1'b0, 1'b0, 8'h00, 8'h00};
      chk({15'h0000, readValid_r}, 16'h0001);
      chk({8'h00, readData_r}, {8'h00, exp});
   endtask

   task automatic test_reset_values();
      chk(targetVolt0_r, 16'h1388);
      chk({2'h0, driveTransPs_r}, 16'h0258);
      chk({12'h000, activeStep_r}, 16'h0000);
      rd(8'h07, 8'h00);
      rd(8'h08, 8'h00);
      rd(8'h3c, 8'h00);
      $display("test_reset_values done");
   endtask

   task automatic test_chip_id();
      // Strap values are arbitrary
      rd(8'h06, 8'h0a);
      otpChipId = 5'h15;
      repeat (6) @(negedge clk_sys);
      rd(8'h06, 8'h15);
      wr(8'h06, 8'hff);
      rd(8'h06, 8'h15);
      $display("test_chip_id done");
   endtask

   task automatic test_drive_trim();
      logic [13:0] expPs [4];
      expPs = '{14'h0258, 14'h04b0, 14'h0708, 14'h1f40};
      for (int i = 0; i < 4; i++) begin
         wr(8'h07, {6'h00, 2'(i)});
         @(negedge clk_sys);
         chk({2'h0, driveTransPs_r}, {2'h0, expPs[i]});
         chk({14'h0000, driveTrim_r}, 16'(i));
      end
      wr(8'h07, 8'hff);
      rd(8'h07, 8'h3f);
      $display("test_drive_trim done");
   endtask

   task automatic test_step_copies();
      wr(8'h07, 8'h00);
      wr(8'h08, 8'h10);
      wr(8'h07, 8'h38);
      @(negedge clk_sys);
      chk({12'h000, activeStep_r}, 16'h0000);
      otherTargetWrite = 3'h5;
      @(negedge clk_sys);
      otherTargetWrite = 3'h0;
      chk({12'h000, activeStep_r}, 16'h000a);
      otherTargetWrite = 3'h2;
      @(negedge clk_sys);
      otherTargetWrite = 3'h0;
      chk({12'h000, activeStep_r}, 16'h000e);
      wr(8'h07, 8'h04);
      @(negedge clk_sys);
      chk({12'h000, activeStep_r}, 16'h000e);
      chk(targetVolt0_r, 16'h1388 + 16'h0fa0);
      wr(8'h08, 8'h10);
      chk({12'h000, activeStep_r}, 16'h000f);
      @(negedge clk_sys);
      chk(targetVolt0_r, 16'h1388 + 16'h07d0);
      $display("test_step_copies done");
   endtask

   task automatic test_codes();
      logic [7:0]  code [3];
      logic [15:0] expV [3];
      code = '{8'h00, 8'hc8, 8'hc9};
      expV = '{16'h1388, 16'hd6d8, 16'hd6d8};
      wr(8'h07, 8'h00);
      for (int i = 0; i < 3; i++) begin
         wr(8'h08, code[i]);
         @(negedge clk_sys);
         chk(targetVolt0_r, expV[i]);
         chk({15'h0000, targetReserved0_r}, {15'h0000, i == 2});
         chk({8'h00, targetCode0_r}, {8'h00, code[i]});
         rd(8'h08, code[i]);
      end
      wr(8'h07, 8'h04);
      wr(8'h08, 8'hff);
      @(negedge clk_sys);
      chk(targetVolt0_r, 16'h900b);
      chk({15'h0000, targetReserved0_r}, 16'h0000);
      wr(8'h08, 8'h01);
      @(negedge clk_sys);
      chk(targetVolt0_r, 16'h1405);
      $display("test_codes done");
   endtask

   initial begin
      n_fail = 0;
      n_tests = 0;
      reset = 1'b1;
      regReq = '{1'b0, 1'b0, 8'h00, 8'h00};
      otpChipId = 5'h0a;
      otherTargetWrite = 3'h0;
      repeat (8) @(negedge clk_sys);
      reset = 1'b0;
      test_reset_values();
      test_chip_id();
      test_drive_trim();
      test_step_copies();
      test_codes();
      give_verdict();
   end

   // Tests need under a hundred cycles; allow far more
   initial begin
      #25000;
      n_fail++;
      give_verdict();
   end
endmodule

`default_nettype wire
